//--- lane_io_pkg.sv
// Purpose: Shared constants and carriers for the 100G lane interface.
// Assumes: Ten receive lanes, four of them wide, one core clock.
// Notes: Lane words carry a 16-bit upper group above a 64-bit main group.
`default_nettype none
package lane_io_pkg;
    localparam int NUM_LANES = 10;
    localparam int WIDE_LANES = 4;
    localparam int UPPER_W = 16;
    localparam int MAIN_W = 64;
    localparam int NARROW_W = 32;
    localparam int LANE_IDX_W = 4;
    localparam int GAP_W = 4;
    localparam int FIFO_DEPTH = 4;
    localparam logic [3:0] GAP_MIN_SETTING = 4'h8;
    localparam logic [3:0] GAP_MAX_SETTING = 4'hC;
    localparam logic [4:0] IDLE_UNIT_MASK = 5'h1C;
    localparam logic [4:0] DEFICIT_MASK = 5'h03;
    localparam logic [3:0] RR_RESET = 4'h0;
    localparam logic [3:0] LAST_LANE = 4'h9;

    typedef struct packed {
        logic [UPPER_W-1:0] upper;
        logic [MAIN_W-1:0] main;
    } lane_word_t;

    typedef struct packed {
        logic [LANE_IDX_W-1:0] lane;
        lane_word_t word;
    } rx_item_t;

    typedef struct packed {
        lane_word_t hold;
        logic req;
        logic ack_s1;
        logic ack_s2;
        logic mode_s1;
        logic mode_s2;
        logic overrun;
    } rx_lane_state_t;

    typedef struct packed {
        lane_word_t data;
        logic req_s1;
        logic req_s2;
        logic ack;
    } tx_lane_state_t;

    typedef struct packed {
        logic valid;
        logic [GAP_W-1:0] term_bytes;
    } pkt_end_t;

    typedef struct packed {
        logic valid;
        logic [GAP_W-1:0] bytes;
    } idle_req_t;
endpackage : lane_io_pkg
`default_nettype wire

//--- lane_fifo.sv
// Purpose: Small FIFO with a registered output stage.
// Assumes: One clock; valid and ready on both sides.
// Notes: Holds DEPTH words in memory plus one in the output register.
`default_nettype none
module lane_fifo #(
    parameter int WIDTH = 84,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
        logic ovalid;
        logic [WIDTH-1:0] odata;
        logic iready;
    } fifo_state_t;

    fifo_state_t st_reg;
    fifo_state_t st_next;
    logic push;
    logic pop;

    always_comb begin
        st_next = st_reg;
        push = in_valid && st_reg.iready;
        pop = (st_reg.count != '0) && (!st_reg.ovalid || out_ready);
        if (out_ready) begin
            st_next.ovalid = 1'b0;
        end
        if (pop) begin
            st_next.odata = st_reg.mem[st_reg.rd];
            st_next.ovalid = 1'b1;
            st_next.rd = AW'(st_reg.rd + 1'b1);
        end
        if (push) begin
            st_next.mem[st_reg.wr] = in_data;
            st_next.wr = AW'(st_reg.wr + 1'b1);
        end
        st_next.count = (AW+1)'(st_reg.count + push - pop);
        // Ready is registered, so it reflects the count after this edge
        st_next.iready = st_next.count < (AW+1)'(DEPTH);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
            st_reg.iready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign in_ready = st_reg.iready;
    assign out_valid = st_reg.ovalid;
    assign out_data = st_reg.odata;
endmodule : lane_fifo
`default_nettype wire

//--- ethernet_lane_io.sv
// Purpose: Receive lane capture, transmit lane drive and idle gap control.
// Assumes: Each lane clock is unrelated to core_clk; nrst reaches all.
// Notes: Lane words cross by a toggle handshake, one word in flight.
`default_nettype none
module ethernet_lane_io
    import lane_io_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic caui4_mode,
    input wire logic [NUM_LANES-1:0] rx_lane_clock,
    input wire logic [UPPER_W-1:0] rx_lane_upper_group [WIDE_LANES],
    input wire logic [MAIN_W-1:0] rx_lane_main_group [WIDE_LANES],
    input wire logic [NARROW_W-1:0] rx_lane_narrow_group [NUM_LANES-WIDE_LANES],
    output logic rx_item_valid,
    output rx_item_t rx_item,
    input wire logic rx_item_ready,
    output logic [NUM_LANES-1:0] rx_overrun,
    input wire logic [WIDE_LANES-1:0] tx_lane_clock,
    input wire lane_word_t tx_word [WIDE_LANES],
    input wire logic [WIDE_LANES-1:0] tx_word_valid,
    output logic [WIDE_LANES-1:0] tx_word_ready,
    output logic [UPPER_W-1:0] tx_lane_upper_group [WIDE_LANES],
    output logic [MAIN_W-1:0] tx_lane_main_group [WIDE_LANES],
    input wire logic [GAP_W-1:0] tx_gap_setting,
    input wire pkt_end_t pkt_end,
    output idle_req_t idle_req
);
    typedef struct packed {
        logic [NUM_LANES-1:0] req_s1;
        logic [NUM_LANES-1:0] req_s2;
        logic [NUM_LANES-1:0] ack;
        logic [NUM_LANES-1:0] ovr_s1;
        logic [NUM_LANES-1:0] ovr_s2;
        logic [LANE_IDX_W-1:0] rr;
        logic [WIDE_LANES-1:0] tx_req;
        logic [WIDE_LANES-1:0] tx_ack_s1;
        logic [WIDE_LANES-1:0] tx_ack_s2;
        logic [WIDE_LANES-1:0] tx_ready;
        logic [WIDE_LANES-1:0][$bits(lane_word_t)-1:0] tx_hold;
        logic [4:0] deficit;
        idle_req_t idle;
    } core_state_t;

    core_state_t st_reg;
    core_state_t st_next;

    lane_word_t lane_hold [NUM_LANES];
    logic [NUM_LANES-1:0] lane_req;
    logic [NUM_LANES-1:0] lane_ovr;
    logic [WIDE_LANES-1:0] tx_lane_ack;

    logic push_valid;
    logic push_ready;
    rx_item_t push_item;
    logic [NUM_LANES-1:0] pending;
    logic [LANE_IDX_W-1:0] pick;
    logic pick_ok;

    // Round-robin choice of the next pending lane, starting at the pointer
    function automatic logic [LANE_IDX_W:0] next_pending(
        input logic [NUM_LANES-1:0] pend,
        input logic [LANE_IDX_W-1:0] start
    );
        logic [LANE_IDX_W:0] result;
        logic [LANE_IDX_W-1:0] idx;
        result = '0;
        for (int k = NUM_LANES - 1; k >= 0; k--) begin
            idx = LANE_IDX_W'((int'(start) + k) % NUM_LANES);
            if (pend[idx]) begin
                result = {1'b1, idx};
            end
        end
        return result;
    endfunction : next_pending

    // Receive lanes: each captures on its own clock
    genvar g;
    generate
        for (g = 0; g < NUM_LANES; g++) begin : g_rx
            rx_lane_state_t ls_reg;
            rx_lane_state_t ls_next;
            lane_word_t word_in;

            // Split by generate so no lane indexes a bus it does not have
            if (g < WIDE_LANES) begin : g_wide
                always_comb begin
                    word_in = '0;
                    if (ls_reg.mode_s2) begin
                        word_in.upper = rx_lane_upper_group[g];
                        word_in.main = rx_lane_main_group[g];
                    end else begin
                        // Upper 48 bits ignored in the ten-lane mode
                        word_in.main[NARROW_W-1:0] =
                            rx_lane_main_group[g][NARROW_W-1:0];
                    end
                end
            end else begin : g_narrow
                always_comb begin
                    word_in = '0;
                    word_in.main[NARROW_W-1:0] =
                        rx_lane_narrow_group[g-WIDE_LANES];
                end
            end

            always_comb begin
                ls_next = ls_reg;
                ls_next.mode_s1 = caui4_mode;
                ls_next.mode_s2 = ls_reg.mode_s1;
                ls_next.ack_s1 = st_reg.ack[g];
                ls_next.ack_s2 = ls_reg.ack_s1;
                if (ls_reg.req == ls_reg.ack_s2) begin
                    ls_next.hold = word_in;
                    ls_next.req = !ls_reg.req;
                end else begin
                    // Core has not taken the last word yet; this one is lost
                    ls_next.overrun = 1'b1;
                end
            end

            always_ff @(posedge rx_lane_clock[g] or negedge nrst) begin
                if (!nrst) begin
                    ls_reg <= '0;
                end else begin
                    ls_reg <= ls_next;
                end
            end

            assign lane_hold[g] = ls_reg.hold;
            assign lane_req[g] = ls_reg.req;
            assign lane_ovr[g] = ls_reg.overrun;
        end
    endgenerate

    // Transmit lanes: each drives on its own clock
    generate
        for (g = 0; g < WIDE_LANES; g++) begin : g_tx
            tx_lane_state_t ts_reg;
            tx_lane_state_t ts_next;

            always_comb begin
                ts_next = ts_reg;
                ts_next.req_s1 = st_reg.tx_req[g];
                ts_next.req_s2 = ts_reg.req_s1;
                if (ts_reg.req_s2 != ts_reg.ack) begin
                    // Hold is stable: it changes only after our ack returns
                    ts_next.data = lane_word_t'(st_reg.tx_hold[g]);
                    ts_next.ack = ts_reg.req_s2;
                end
            end

            always_ff @(posedge tx_lane_clock[g] or negedge nrst) begin
                if (!nrst) begin
                    ts_reg <= '0;
                end else begin
                    ts_reg <= ts_next;
                end
            end

            assign tx_lane_upper_group[g] = ts_reg.data.upper;
            assign tx_lane_main_group[g] = ts_reg.data.main;
            assign tx_lane_ack[g] = ts_reg.ack;
        end
    endgenerate

    // Core side of the receive handshakes
    assign pending = st_reg.req_s2 ^ st_reg.ack;
    assign {pick_ok, pick} = next_pending(pending, st_reg.rr);
    assign push_valid = pick_ok;
    assign push_item.lane = pick;
    assign push_item.word = lane_hold[pick];

    always_comb begin
        logic [4:0] acc;
        acc = '0;
        st_next = st_reg;
        st_next.req_s1 = lane_req;
        st_next.req_s2 = st_reg.req_s1;
        st_next.ovr_s1 = lane_ovr;
        st_next.ovr_s2 = st_reg.ovr_s1;

        // A full FIFO withholds the ack, which stalls the lane
        if (push_valid && push_ready) begin
            st_next.ack[pick] = !st_reg.ack[pick];
            st_next.rr = (pick == LAST_LANE) ? RR_RESET
                : LANE_IDX_W'(pick + 1'b1);
        end

        st_next.tx_ack_s1 = tx_lane_ack;
        st_next.tx_ack_s2 = st_reg.tx_ack_s1;
        for (int i = 0; i < WIDE_LANES; i++) begin
            if (tx_word_valid[i] && st_reg.tx_ready[i]) begin
                st_next.tx_hold[i] = tx_word[i];
                st_next.tx_req[i] = !st_reg.tx_req[i];
            end
            st_next.tx_ready[i] =
                (st_next.tx_req[i] == st_reg.tx_ack_s2[i]);
        end

        st_next.idle = '0;
        if (pkt_end.valid) begin
            st_next.idle.valid = 1'b1;
            if (tx_gap_setting >= GAP_MIN_SETTING &&
                tx_gap_setting <= GAP_MAX_SETTING) begin
                // Deficit carries the fraction below one idle unit forward
                if ({1'b0, tx_gap_setting} + st_reg.deficit >
                    {1'b0, pkt_end.term_bytes}) begin
                    acc = 5'({1'b0, tx_gap_setting} + st_reg.deficit
                        - {1'b0, pkt_end.term_bytes});
                end
                st_next.idle.bytes = GAP_W'(acc & IDLE_UNIT_MASK);
                st_next.deficit = acc & DEFICIT_MASK;
            end else begin
                // Terminate word gap only; nothing banked
                st_next.idle.bytes = '0;
                st_next.deficit = '0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
            st_reg.tx_ready <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    lane_fifo #(
        .WIDTH($bits(rx_item_t)),
        .DEPTH(DEPTH)
    ) u_rx_fifo (
        .clk(core_clk),
        .nrst(nrst),
        .in_valid(push_valid),
        .in_data(push_item),
        .in_ready(push_ready),
        .out_valid(rx_item_valid),
        .out_data(rx_item),
        .out_ready(rx_item_ready)
    );

    assign rx_overrun = st_reg.ovr_s2;
    assign tx_word_ready = st_reg.tx_ready;
    assign idle_req = st_reg.idle;
endmodule : ethernet_lane_io
`default_nettype wire

//--- lane_io_asserts.sv
// Purpose: Port assertions for the lane interface.
// Assumes: Core clock domain only.
// Notes: Lane-side timing is judged by the bench.
`default_nettype none
module lane_io_asserts
    import lane_io_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic rx_item_valid,
    input wire rx_item_t rx_item,
    input wire logic rx_item_ready,
    input wire logic [WIDE_LANES-1:0] tx_word_valid,
    input wire logic [WIDE_LANES-1:0] tx_word_ready,
    input wire logic [GAP_W-1:0] tx_gap_setting,
    input wire pkt_end_t pkt_end,
    input wire idle_req_t idle_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    gap_pulse_a: assert property (pkt_end.valid |=> idle_req.valid)
        else $error("idle pulse missing");
    gap_quiet_a: assert property (!pkt_end.valid |=> !idle_req.valid)
        else $error("stray idle pulse");
    gap_grain_a: assert property (
        idle_req.valid |-> idle_req.bytes[1:0] == 2'h0)
        else $error("idle bytes not whole units");
    gap_minimal_a: assert property (
        pkt_end.valid && (tx_gap_setting < 4'h8 || tx_gap_setting > 4'hC)
        |=> idle_req.bytes == 4'h0) else $error("idles added in minimal mode");
    gap_bound_a: assert property (pkt_end.valid |=>
        5'(idle_req.bytes) + 5'($past(pkt_end.term_bytes))
        <= 5'($past(tx_gap_setting)) + 5'h03 || idle_req.bytes == 4'h0)
        else $error("idle bytes above target");
    item_hold_a: assert property (rx_item_valid && !rx_item_ready
        |=> rx_item_valid && $stable(rx_item)) else $error("item not held");
    narrow_lane_a: assert property (
        rx_item_valid && rx_item.lane >= 4'h4 |-> rx_item.word[79:32] == '0)
        else $error("narrow lane carries wide data");
    tx_ready_a: assert property (
        tx_word_valid[0] && tx_word_ready[0] |=> !tx_word_ready[0])
        else $error("transmit ready not dropped");
endmodule : lane_io_asserts
bind ethernet_lane_io lane_io_asserts lane_io_asserts_inst (.core_clk, .nrst,
    .rx_item_valid, .rx_item, .rx_item_ready, .tx_word_valid, .tx_word_ready,
    .tx_gap_setting, .pkt_end, .idle_req);
`default_nettype wire

//--- lane_xcvr_model.sv
// Purpose: Transceiver lanes around the lane interface.
// Assumes: One word per receive frame of four lane clock edges.
// Notes: Busy edges carry the inverted word, so a copy must never land.
`default_nettype none
module lane_xcvr_model
    import lane_io_pkg::*;
(
    output logic [NUM_LANES-1:0] rx_lane_clock,
    output logic [UPPER_W-1:0] rx_lane_upper_group [WIDE_LANES],
    output logic [MAIN_W-1:0] rx_lane_main_group [WIDE_LANES],
    output logic [NARROW_W-1:0] rx_lane_narrow_group [NUM_LANES-WIDE_LANES],
    output logic [WIDE_LANES-1:0] tx_lane_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_lane_clock = '0;
        rx_lane_upper_group = '{default: '1};
        rx_lane_main_group = '{default: '1};
        rx_lane_narrow_group = '{default: '1};
        tx_lane_clock = 4'h5;
        forever #16 tx_lane_clock = ~tx_lane_clock;
    end
    // Edge 0 captures; edges 1..3 fall while the word is in flight.
    // A fifth edge would find the lane free again and take a copy.
    task automatic send(input logic [3:0] lane, input logic [79:0] w);
        for (int e = 0; e < 4; e++) begin
            if (lane < 4'h4) begin
                rx_lane_upper_group[lane[1:0]] = e ? ~w[79:64] : w[79:64];
                rx_lane_main_group[lane[1:0]] = e ? ~w[63:0] : w[63:0];
            end else begin
                rx_lane_narrow_group[lane - 4'h4] = e ? ~w[31:0] : w[31:0];
            end
            #16 rx_lane_clock[lane] = 1'b1;
            #16 rx_lane_clock[lane] = 1'b0;
        end
    endtask : send
endmodule : lane_xcvr_model
`default_nettype wire

//--- test_ethernet_lane_io.sv
// Purpose: Self-checking bench for the lane interface.
// Assumes: Receive lanes are fed one at a time, so item order is known.
// Notes: Words, backpressure and the gap settings after the first 16 come from xorshift.
`default_nettype none
module test_ethernet_lane_io;
    import lane_io_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, nrst, caui4_mode, rx_item_valid, rx_item_ready;
    logic [NUM_LANES-1:0] rx_lane_clock, rx_overrun;
    logic [UPPER_W-1:0] rx_lane_upper_group [WIDE_LANES];
    logic [MAIN_W-1:0] rx_lane_main_group [WIDE_LANES];
    logic [NARROW_W-1:0] rx_lane_narrow_group [NUM_LANES-WIDE_LANES];
    logic [UPPER_W-1:0] tx_lane_upper_group [WIDE_LANES];
    logic [MAIN_W-1:0] tx_lane_main_group [WIDE_LANES];
    logic [WIDE_LANES-1:0] tx_lane_clock, tx_word_valid, tx_word_ready;
    lane_word_t tx_word [WIDE_LANES];
    rx_item_t rx_item, e;
    logic [GAP_W-1:0] tx_gap_setting;
    pkt_end_t pkt_end;
    idle_req_t idle_req;
    rx_item_t rx_q[$];
    logic [GAP_W-1:0] gap_q[$];
    logic [31:0] seed = 32'h0000C475;
    logic [95:0] w;
    int n_tests, n_errors, k, d, acc, s, t;
    ethernet_lane_io ethernet_lane_io_inst (.core_clk, .nrst, .caui4_mode,
        .rx_lane_clock, .rx_lane_upper_group, .rx_lane_main_group,
        .rx_lane_narrow_group, .rx_item_valid, .rx_item, .rx_item_ready,
        .rx_overrun, .tx_lane_clock, .tx_word, .tx_word_valid, .tx_word_ready,
        .tx_lane_upper_group, .tx_lane_main_group, .tx_gap_setting, .pkt_end,
        .idle_req);
    lane_xcvr_model lane_xcvr_model_inst (.rx_lane_clock, .rx_lane_upper_group,
        .rx_lane_main_group, .rx_lane_narrow_group, .tx_lane_clock);
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic check(input string what, input logic [83:0] seen,
        input logic [83:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task automatic expire();
        if (k >= 200) begin
            check("wait", 84'h0, 84'h1);
            close_out();
        end
    endtask : expire
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        rx_item_ready <= rnd() > 32'h60000000;
        if (rx_item_valid === 1'b1 && rx_item_ready === 1'b1) begin
            check("rx_item", rx_item, rx_q.size() ? rx_q.pop_front() : 'x);
        end
        if (idle_req.valid === 1'b1) begin
            check("idle", idle_req.bytes, gap_q.size() ? gap_q.pop_front() : 'x);
        end
    end
    initial begin
        nrst <= 1'b0;
        caui4_mode <= 1'b1;
        tx_word <= '{default: '0};
        tx_word_valid <= '0;
        tx_gap_setting <= '0;
        pkt_end <= '0;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        for (int i = 0; i < WIDE_LANES; i++) begin
            w = {rnd(), rnd(), rnd()};
            tx_word[i] <= w[79:0];
            tx_word_valid[i] <= 1'b1;
            @(posedge core_clk);
            for (k = 0; k < 200 && tx_word_ready[i] !== 1'b1; k++) @(posedge core_clk);
            expire();
            tx_word_valid[i] <= 1'b0;
            @(posedge core_clk);
            for (k = 0; k < 200 && tx_word_ready[i] !== 1'b1; k++) @(posedge core_clk);
            expire();
            check("tx upper", tx_lane_upper_group[i], w[79:64]);
            check("tx main", tx_lane_main_group[i], w[63:0]);
        end
        $display("transmit lanes done");
        for (int m = 1; m >= 0; m--) begin
            caui4_mode <= m[0];
            for (int l = 0; l < NUM_LANES + WIDE_LANES; l++) begin
                w = {rnd(), rnd(), rnd()};
                // First visits are mode-neutral while the mode syncs into lanes
                if (l < WIDE_LANES) w[79:32] = '0;
                e.lane = 4'(l % NUM_LANES);
                e.word = (m == 1 && e.lane < 4'h4) ? w[79:0] : {48'h0, w[31:0]};
                rx_q.push_back(e);
                lane_xcvr_model_inst.send(e.lane, w[79:0]);
                for (k = 0; k < 200 && rx_q.size() > 0; k++) @(posedge core_clk);
                expire();
            end
            $display("receive lanes done, mode %0d", m);
        end
        for (int p = 0; p < 48; p++) begin
            w[31:0] = rnd();
            s = (p < 16) ? p : int'(w[3:0]);
            t = int'(w[7:4]);
            tx_gap_setting <= 4'(s);
            pkt_end <= '{1'b1, 4'(t)};
            acc = (s >= 8 && s <= 12 && s + d > t) ? s + d - t : 0;
            gap_q.push_back(4'(acc & 12));
            d = acc % 4;
            @(posedge core_clk);
        end
        pkt_end <= '0;
        repeat (3) @(posedge core_clk);
        check("idle left", gap_q.size(), 0);
        check("overrun", rx_overrun, 10'h3FF);
        $display("gap test done");
        close_out();
    end
endmodule : test_ethernet_lane_io
`default_nettype wire
